// File: design/eil_top.sv
// Top of the external request block: APB register, detectors, poll and call sequencer.
// Assumes the core reports instruction state in core_state each cycle and pins are synchronous.
`timescale 1ns/1ns
`default_nettype none
module eil_top #(
    parameter int ADDR_W = eil_pkg::EIL_ADDR_W
) (
    input  wire logic                          ref_clk,
    input  wire logic                          rstn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [ADDR_W-1:0]             paddr,
    input  wire logic [eil_pkg::EIL_DATA_W-1:0] pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic [eil_pkg::EIL_DATA_W-1:0]     prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          ext_req_pin_a_n,
    input  wire logic                          ext_req_pin_b_n,
    input  wire eil_pkg::eil_core_t            core_state,
    output logic [1:0]                         ext_req,
    output eil_pkg::eil_call_t                 call,
    output logic                               wake_up
);
    import eil_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus.
    logic                  hit;
    logic                  wr_acc;
    logic [7:0]            tec_view;
    logic [EIL_DATA_W-1:0] prdata_reg;
    logic [EIL_DATA_W-1:0] prdata_next;
    logic [1:0]            type_reg;
    logic [1:0]            type_next;
    logic [1:0]            flags;
    logic [1:0]            pins_n;

    assign hit    = (paddr == ADDR_W'(EIL_TEC_OFFSET));
    assign wr_acc = psel & penable & pwrite & hit & pstrb[0];
    assign pins_n = {ext_req_pin_b_n, ext_req_pin_a_n};

    always_comb begin
        tec_view                 = EIL_TEC_RESET;
        tec_view[EIL_TYPE_A_BIT] = type_reg[0];
        tec_view[EIL_FLAG_A_BIT] = flags[0];
        tec_view[EIL_TYPE_B_BIT] = type_reg[1];
        tec_view[EIL_FLAG_B_BIT] = flags[1];
    end

    // Read data is caught in the setup cycle so that it comes from a flip-flop with zero wait.
    always_comb begin
        prdata_next = prdata_reg;
        if (psel && !penable && !pwrite) begin
            prdata_next = hit ? {24'h000000, tec_view} : 32'h00000000;
        end
        type_next = type_reg;
        if (wr_acc) begin
            type_next[0] = pwdata[EIL_TYPE_A_BIT];
            type_next[1] = pwdata[EIL_TYPE_B_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            prdata_reg <= 32'h00000000;
            type_reg   <= 2'h0;
        end else begin
            prdata_reg <= prdata_next;
            type_reg   <= type_next;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;

    ////////////////////////////////////////////////////////////////////////////
    // Pin detectors.
    logic [1:0] hw_clear;
    logic [1:0] sw_flag_val;

    assign sw_flag_val = {pwdata[EIL_FLAG_B_BIT], pwdata[EIL_FLAG_A_BIT]};

    genvar gi;
    generate
        for (gi = 0; gi < EIL_NUM_SRC; gi++) begin : g_src
            eil_pin_detect u_det (
                .ref_clk   (ref_clk),
                .rstn      (rstn),
                .pin_n     (pins_n[gi]),
                .edge_mode (type_reg[gi]),
                .sw_we     (wr_acc),
                .sw_val    (sw_flag_val[gi]),
                .hw_clear  (hw_clear[gi]),
                .flag      (flags[gi])
            );
        end
    endgenerate

    assign ext_req = flags;

    assign wake_up = core_state.power_down & (|flags);

    ////////////////////////////////////////////////////////////////////////////
    // Poll and priority resolution, redone from the live flags each cycle.
    eil_state_t state_reg;
    eil_state_t state_next;
    eil_call_t  call_reg;
    eil_call_t  call_next;
    logic [2:0] svc_rank;
    logic [2:0] rank_a;
    logic [2:0] rank_b;
    logic [1:0] pending;
    logic       win_src;
    logic [1:0] win_level;
    logic       can_call;
    logic       accept;
    logic       ret_done;

    assign rank_a = {1'b0, core_state.prio_a} + 3'h1;
    assign rank_b = {1'b0, core_state.prio_b} + 3'h1;

    // equal or higher in service blocks
    assign pending[0] = flags[0] & core_state.src_en[0] & core_state.global_en & (rank_a > svc_rank);
    assign pending[1] = flags[1] & core_state.src_en[1] & core_state.global_en & (rank_b > svc_rank);

    // Ties go to pin a, the higher natural priority.
    assign win_src   = pending[1] & (~pending[0] | (rank_b > rank_a));
    assign win_level = win_src ? core_state.prio_b : core_state.prio_a;

    // no call on return or enable write
    assign can_call = (state_reg == EIL_IDLE) & core_state.last_cycle & ~core_state.is_return
                    & ~core_state.writes_ie_ip;
    assign accept   = can_call & (|pending);

    assign hw_clear = accept ? (win_src ? 2'b10 : 2'b01) : 2'b00;

    assign ret_done = core_state.is_return & core_state.last_cycle;

    eil_in_service u_svc (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .push       (accept),
        .push_level (win_level),
        .pop        (ret_done),
        .top_rank   (svc_rank)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Vector call sequencer.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            EIL_IDLE: begin
                if (accept) begin
                    state_next = EIL_CALL1;
                end
            end
            EIL_CALL1: begin
                state_next = EIL_CALL2;
            end
            EIL_CALL2: begin
                state_next = EIL_CALL3;
            end
            EIL_CALL3: begin
                state_next = EIL_CALL4;
            end
            EIL_CALL4: begin
                state_next = EIL_IDLE;
            end
            default: begin
                state_next = EIL_IDLE;
            end
        endcase
    end

    // block adds only detect and call
    always_comb begin
        call_next.busy      = (state_next != EIL_IDLE);
        call_next.start     = accept;
        call_next.isr_start = (state_reg == EIL_CALL4);
        call_next.source    = accept ? win_src : call_reg.source;
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_reg <= EIL_IDLE;
            call_reg  <= '0;
        end else begin
            state_reg <= state_next;
            call_reg  <= call_next;
        end
    end

    assign call = call_reg;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    property p_fresh_poll;
        (ext_req == 2'b00) |=> !call_reg.start;
    endproperty
    a_fresh_poll: assert property (p_fresh_poll) else $error("call without a live request");

    property p_call_len;
        $rose(call_reg.busy) |-> call_reg.busy[*4] ##1 !call_reg.busy;
    endproperty
    a_call_len: assert property (p_call_len) else $error("vector call not four cycles");

    property p_latency;
        accept |-> ##5 call_reg.isr_start;
    endproperty
    a_latency: assert property (p_latency) else $error("routine start not five cycles after poll");

    property p_bound;
        (|pending && can_call) |-> ##[1:16] call_reg.isr_start;
    endproperty
    a_bound: assert property (p_bound) else $error("routine start beyond worst case");

    property p_last_cycle;
        !core_state.last_cycle |-> !accept;
    endproperty
    a_last_cycle: assert property (p_last_cycle) else $error("call in mid instruction");

    property p_in_service;
        (svc_rank >= rank_a && svc_rank >= rank_b) |-> !accept;
    endproperty
    a_in_service: assert property (p_in_service) else $error("call over equal priority routine");

    property p_type_level;
        !type_reg[0] |-> (ext_req[0] == !ext_req_pin_a_n);
    endproperty
    a_type_level: assert property (p_type_level) else $error("type 0 not level triggered");

    property p_blocked;
        (core_state.is_return || core_state.writes_ie_ip) |-> !accept;
    endproperty
    a_blocked: assert property (p_blocked) else $error("call on return or enable write");

    property p_wake;
        (core_state.power_down && (!ext_req_pin_a_n && !type_reg[0])) |-> wake_up;
    endproperty
    a_wake: assert property (p_wake) else $error("low pin did not wake");

    property p_reset_value;
        $rose(rstn) |-> (type_reg == 2'h0 && state_reg == EIL_IDLE);
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("register not zero after reset");

    property p_edge_cleared;
        (accept && type_reg[0] && !win_src && !($past(ext_req_pin_a_n) && !ext_req_pin_a_n)) |=> !flags[0];
    endproperty
    a_edge_cleared: assert property (p_edge_cleared) else $error("edge flag kept after call");

    property p_edge_b_cleared;
        (accept && type_reg[1] && win_src && !($past(ext_req_pin_b_n) && !ext_req_pin_b_n)) |=> !flags[1];
    endproperty
    a_edge_b_cleared: assert property (p_edge_b_cleared) else $error("edge flag b kept after call");

    property p_no_restart;
        call_reg.busy |-> !accept;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("new call accepted during a call");

    property p_req_b_drives;
        (ext_req[1] == 1'b0) |=> !(call_reg.start && call_reg.source);
    endproperty
    a_req_b_drives: assert property (p_req_b_drives) else $error("call for pin b without its request");

    property p_start_pulse;
        call_reg.start |=> !call_reg.start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("call start longer than one cycle");

endmodule
`default_nettype wire

// File: inc/eil_pkg.sv
// Shared constants, types and decode helpers for the external request block.
// Assumes one system clock and a core that reports its instruction state every cycle.
package eil_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam int             EIL_ADDR_W      = 12;
    localparam int             EIL_DATA_W      = 32;
    localparam int             EIL_NUM_SRC     = 2;
    localparam logic [11:0]    EIL_TEC_OFFSET  = 12'h088;
    localparam logic [7:0]     EIL_TEC_RESET   = 8'h00;
    localparam int             EIL_TYPE_A_BIT  = 0;
    localparam int             EIL_FLAG_A_BIT  = 1;
    localparam int             EIL_TYPE_B_BIT  = 2;
    localparam int             EIL_FLAG_B_BIT  = 3;
    localparam int             EIL_CALL_CYCLES = 4;
    localparam int             EIL_MIN_LATENCY = 5;
    localparam int             EIL_MAX_LATENCY = 16;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic       last_cycle;
        logic       is_return;
        logic       writes_ie_ip;
        logic       power_down;
        logic       global_en;
        logic [1:0] src_en;
        logic [1:0] prio_a;
        logic [1:0] prio_b;
    } eil_core_t;

    typedef struct packed {
        logic busy;
        logic start;
        logic isr_start;
        logic source;
    } eil_call_t;

    typedef enum logic [4:0] {
        EIL_IDLE  = 5'h01,
        EIL_CALL1 = 5'h02,
        EIL_CALL2 = 5'h04,
        EIL_CALL3 = 5'h08,
        EIL_CALL4 = 5'h10
    } eil_state_t;

    // Rank of the highest level in a mask: zero means nothing in service.
    function automatic logic [2:0] eil_rank(input logic [3:0] mask);
        logic [2:0] r;
        r = 3'h0;
        for (int k = 0; k < 4; k++) begin
            if (mask[k]) begin
                r = 3'(k + 1);
            end
        end
        return r;
    endfunction

endpackage

// File: design/eil_pin_detect.sv
// Per-pin request detector: low level or falling edge on an active-low pin.
// Assumes the pin is already synchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none
module eil_pin_detect (
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic pin_n,
    input  wire logic edge_mode,
    input  wire logic sw_we,
    input  wire logic sw_val,
    input  wire logic hw_clear,
    output logic      flag
);
    import eil_pkg::*;

    logic prev_reg;
    logic prev_next;
    logic edge_reg;
    logic edge_next;
    logic fall;

    ////////////////////////////////////////////////////////////////////////////
    // sample compare
    assign fall = prev_reg & ~pin_n;

    always_comb begin
        prev_next = pin_n;
        edge_next = edge_reg;
        if (!edge_mode) begin
            edge_next = 1'b0;
        end else if (fall) begin
            edge_next = 1'b1;
        end else if (hw_clear) begin
            edge_next = 1'b0;
        end else if (sw_we) begin
            edge_next = sw_val;
        end
    end

    // Idle-high reset of the old sample makes a pin held low at reset read as a falling edge in the first cycle.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            prev_reg <= 1'b1;
            edge_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
            edge_reg <= edge_next;
        end
    end

    assign flag = edge_mode ? edge_reg : ~pin_n;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    property p_edge_sets;
        (edge_mode && $past(edge_mode) && $past(pin_n) && !pin_n) |=> flag;
    endproperty
    a_edge_sets: assert property (p_edge_sets) else $error("falling edge did not set flag");

    property p_edge_holds;
        (edge_mode && flag && !hw_clear && !sw_we) ##1 edge_mode |-> flag;
    endproperty
    a_edge_holds: assert property (p_edge_holds) else $error("edge flag dropped by itself");

    property p_level_follows;
        !edge_mode |-> (flag == !pin_n);
    endproperty
    a_level_follows: assert property (p_level_follows) else $error("level flag not inverse of pin");

    property p_level_no_hw_clear;
        (!edge_mode && !pin_n && hw_clear) ##1 (!edge_mode && !pin_n) |-> flag;
    endproperty
    a_level_no_hw_clear: assert property (p_level_no_hw_clear) else $error("level flag cleared on call");

endmodule
`default_nettype wire

// File: design/eil_in_service.sv
// Tracks which priority levels have a service routine under way.
// Assumes a return cannot coincide with a new vector call.
`timescale 1ns/1ns
`default_nettype none
module eil_in_service (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       push,
    input  wire logic [1:0] push_level,
    input  wire logic       pop,
    output logic [2:0]      top_rank
);
    import eil_pkg::*;

    logic [3:0] mask_reg;
    logic [3:0] mask_next;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        mask_next = mask_reg;
        if (pop && (top_rank != 3'h0)) begin
            mask_next[2'(top_rank - 3'h1)] = 1'b0;
        end
        if (push) begin
            mask_next[push_level] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            mask_reg <= 4'h0;
        end else begin
            mask_reg <= mask_next;
        end
    end

    assign top_rank = eil_rank(mask_reg);

endmodule
`default_nettype wire

// File: testbench/eil_req_source.sv
// Model of the outside sources that drive the two active-low request pins.
// Assumes the bench raises want_a or want_b to ask for a request on a pin.
`timescale 1ns/1ns
`default_nettype none
module eil_req_source (
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic want_a,
    input  wire logic want_b,
    output logic      pin_a_n,
    output logic      pin_b_n
);
    ////////////////////////////////////////////////////////////////////////////
    // hold pin levels.
    // Registered, so each level lasts at least one whole clock; a request stays low until the bench drops it.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pin_a_n <= 1'b1;
            pin_b_n <= 1'b1;
        end else begin
            pin_a_n <= ~want_a;
            pin_b_n <= ~want_b;
        end
    end
endmodule
`default_nettype wire

// File: testbench/tb_external_interrupt_latency.sv
// Self-checking bench for the external request block: register, detectors and vector call timing.
// Assumes the design files, the package and the pin source model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_external_interrupt_latency;
    import eil_pkg::*;
    logic                  ref_clk;
    logic                  rstn;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [EIL_ADDR_W-1:0] paddr;
    logic [EIL_DATA_W-1:0] pwdata;
    logic [3:0]            pstrb;
    logic [EIL_DATA_W-1:0] prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  pin_a_n;
    logic                  pin_b_n;
    logic                  want_a;
    logic                  want_b;
    eil_core_t             core;
    logic [1:0]            ext_req;
    eil_call_t             call;
    logic                  wake_up;
    int                    mismatches;
    int                    cmp_count;
    logic [31:0]           rd;
    logic                  err;

    eil_top uut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_req_pin_a_n(pin_a_n), .ext_req_pin_b_n(pin_b_n),
        .core_state(core), .ext_req(ext_req), .call(call), .wake_up(wake_up));
    eil_req_source src (.ref_clk(ref_clk), .rstn(rstn), .want_a(want_a), .want_b(want_b),
        .pin_a_n(pin_a_n), .pin_b_n(pin_b_n));

    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic fail_out();
        mismatches++;
        $display("[ERR] %0t wait ran out", $time);
        print_verdict();
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [EIL_ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fail_out();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdreg();
        apb(1'b0, EIL_TEC_OFFSET, 32'h0);
    endtask

    // Counts falling edges until the call pulse, busy cycles and routine start.
    task automatic watch(output int ts, output int nb, output int ti);
        ts = 0;
        nb = 0;
        ti = 0;
        for (int i = 1; i <= 24 && ti == 0; i++) begin
            @(negedge ref_clk);
            if (call.start === 1'b1 && ts == 0) ts = i;
            if (call.busy === 1'b1) nb++;
            if (call.isr_start === 1'b1) ti = i;
        end
        if (ti == 0) fail_out();
    endtask

    // Counts call pulses over n cycles; a blocked poll must give none.
    task automatic quiet(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(negedge ref_clk);
            if (call.start !== 1'b0) c++;
        end
    endtask

    task automatic do_return();
        @(posedge ref_clk);
        core.is_return <= 1'b1;
        @(posedge ref_clk);
        core.is_return <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdreg();
        chk(rd, 32'h0);
        apb(1'b1, 12'h08c, 32'h5);
        chk(err, 1'b1);
        rdreg();
        chk(rd, 32'h0);
    endtask

    task automatic t_sw();
        @(posedge ref_clk);
        core.src_en <= 2'b00;
        apb(1'b1, EIL_TEC_OFFSET, 32'h5);
        apb(1'b1, EIL_TEC_OFFSET, 32'hf);
        rdreg();
        chk(rd, 32'hf);
        apb(1'b1, EIL_TEC_OFFSET, 32'h5);
        rdreg();
        chk(rd, 32'h5);
        apb(1'b1, EIL_TEC_OFFSET, 32'h0);
        apb(1'b1, EIL_TEC_OFFSET, 32'ha);
        rdreg();
        chk(rd, 32'h0);
        pstrb <= 4'h0;
        apb(1'b1, EIL_TEC_OFFSET, 32'h5);
        pstrb <= 4'hf;
        rdreg();
        chk(rd, 32'h0);
    endtask

    task automatic t_edge(input logic s);
        int ts, nb, ti, k;
        apb(1'b1, EIL_TEC_OFFSET, 32'h5);
        core.src_en <= 2'b11;
        @(posedge ref_clk);
        if (s) want_b <= 1'b1;
        else want_a <= 1'b1;
        k = 0;
        do begin
            @(negedge ref_clk);
            k++;
        end while (ext_req[s] !== 1'b1 && k < 8);
        if (k >= 8) fail_out();
        watch(ts, nb, ti);
        chk(ts, 1);
        chk(nb, EIL_CALL_CYCLES);
        chk(ti, EIL_MIN_LATENCY);
        chk(k + ti <= EIL_MAX_LATENCY, 1'b1);
        chk(call.source, s);
        chk(ext_req[s], 1'b0);
        @(posedge ref_clk);
        want_a <= 1'b0;
        want_b <= 1'b0;
        do_return();
    endtask

    task automatic t_level();
        int ts, nb, ti, c;
        apb(1'b1, EIL_TEC_OFFSET, 32'h0);
        core.last_cycle <= 1'b0;
        want_a <= 1'b1;
        repeat (3) @(posedge ref_clk);
        want_a <= 1'b0;
        repeat (3) @(posedge ref_clk);
        core.last_cycle <= 1'b1;
        quiet(6, c);
        chk(c, 0);
        @(posedge ref_clk);
        core.last_cycle <= 1'b0;
        want_a <= 1'b1;
        quiet(6, c);
        chk(c, 0);
        chk(ext_req, 2'b01);
        @(posedge ref_clk);
        core.last_cycle <= 1'b1;
        core.writes_ie_ip <= 1'b1;
        quiet(4, c);
        chk(c, 0);
        @(posedge ref_clk);
        core.writes_ie_ip <= 1'b0;
        core.is_return <= 1'b1;
        quiet(4, c);
        chk(c, 0);
        @(posedge ref_clk);
        core.is_return <= 1'b0;
        watch(ts, nb, ti);
        chk(ti - ts, EIL_CALL_CYCLES);
        chk(ext_req, 2'b01);
        quiet(6, c);
        chk(c, 0);
        do_return();
        watch(ts, nb, ti);
        chk(call.source, 1'b0);
        @(posedge ref_clk);
        want_a <= 1'b0;
        do_return();
    endtask

    task automatic t_prio();
        int ts, nb, ti;
        @(posedge ref_clk);
        core.prio_b <= 2'b01;
        want_a <= 1'b1;
        watch(ts, nb, ti);
        chk(call.source, 1'b0);
        @(posedge ref_clk);
        want_b <= 1'b1;
        watch(ts, nb, ti);
        chk(call.source, 1'b1);
        @(posedge ref_clk);
        want_a <= 1'b0;
        want_b <= 1'b0;
        do_return();
        do_return();
    endtask

    task automatic t_wake();
        @(posedge ref_clk);
        core.src_en <= 2'b00;
        core.power_down <= 1'b1;
        want_b <= 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(wake_up, 1'b1);
        @(posedge ref_clk);
        want_b <= 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(wake_up, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mismatches = 0;
        cmp_count = 0;
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hf;
        want_a = 1'b0;
        want_b = 1'b0;
        core = '{last_cycle: 1'b1, global_en: 1'b1, src_en: 2'b11, default: '0};
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_sw();
        t_edge(1'b0);
        t_edge(1'b1);
        t_level();
        t_prio();
        t_wake();
        print_verdict();
    end
endmodule
`default_nettype wire
